// [hw/pdp_pkg.sv]
// Shared constants and types for the palette and DAC pixel path
package pdp_pkg;

  // ==========================================================================
  // Palette I/O port addresses
  localparam logic [15:0] PORT_STATUS = 16'h03C2;
  localparam logic [15:0] PORT_MASK = 16'h03C6;
  localparam logic [15:0] PORT_RD_INDEX = 16'h03C7;
  localparam logic [15:0] PORT_WR_INDEX = 16'h03C8;
  localparam logic [15:0] PORT_DATA = 16'h03C9;

  // ==========================================================================
  // Field positions and codes of the control registers
  localparam int CM_MODE_LSB = 4;
  localparam int CM_COMP_LSB = 2;
  localparam logic [1:0] COMP_ON = 2'h3;
  localparam int TV_EN_BIT = 0;
  localparam int TV_FMT_LSB = 1;
  localparam int TV_MONO_BIT = 4;
  localparam int TV_PAL_BIT = 5;
  localparam logic [1:0] TV_FMT_SVIDEO = 2'h0;
  localparam logic [1:0] TWS_MIRROR = 2'h0;
  localparam logic [1:0] TWS_FIRST = 2'h1;
  localparam logic [1:0] TWS_SECOND = 2'h2;
  localparam int SENSE_BIT = 4;
  localparam int ABR_RD_RETRY = 0;
  localparam int ABR_MABORT = 1;
  localparam int ABR_WR_RETRY = 2;

  // ==========================================================================
  // Color mode codes
  localparam logic [3:0] MODE_INDEXED = 4'h0;
  localparam logic [3:0] MODE_DOUBLED = 4'h1;
  localparam logic [3:0] MODE_HI15 = 4'h3;
  localparam logic [3:0] MODE_HI16 = 4'h5;
  localparam logic [3:0] MODE_PACKED24 = 4'h7;
  localparam logic [3:0] MODE_TRUE24 = 4'hD;

  // ==========================================================================
  // Reset values and table geometry
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam int LUT_DEPTH = 256;
  localparam int LUT_AW = 8;
  localparam int ENTRY_W = 18;
  localparam int NUM_TABLES = 2;

  // ==========================================================================
  // Rate limits per mode, in Hz, and the block's own clock
  localparam int CLOCK_HZ = 25_000_000;
  localparam int DOT_HZ_DOUBLED = CLOCK_HZ / 2;
  localparam int MAX_HZ_80 = 80_000_000;
  localparam int MAX_DOT_HZ_DOUBLED = 67_500_000;
  localparam int MAX_PIX_HZ_DOUBLED = 135_000_000;
  localparam int MAX_DOT_HZ_PACKED24 = 75_000_000;
  localparam int MAX_PIX_HZ_PACKED24 = 25_000_000;
  localparam int MAX_HZ_TRUE24 = 50_000_000;

  // ==========================================================================
  // Color component sequencer for palette data port accesses
  typedef enum logic [2:0] {
    CMP_RED = 3'b001,
    CMP_GREEN = 3'b010,
    CMP_BLUE = 3'b100
  } pdp_cmp_t;

endpackage : pdp_pkg

// [hw/pdp_lut_if.sv]
// Connection between the pixel path control and its palette memory
interface pdp_lut_if;
  logic [1:0] wr_en;
  logic [7:0] wr_addr;
  logic [17:0] wr_data;
  logic [7:0] pix_addr;
  logic pix_table;
  logic [17:0] pix_data;
  logic [7:0] cpu_addr;
  logic cpu_table;
  logic [17:0] cpu_data;

  modport ctrl (
    output wr_en, wr_addr, wr_data, pix_addr, pix_table, cpu_addr, cpu_table,
    input pix_data, cpu_data
  );
  modport mem (
    input wr_en, wr_addr, wr_data, pix_addr, pix_table, cpu_addr, cpu_table,
    output pix_data, cpu_data
  );
endinterface : pdp_lut_if

// [hw/pdp_palette_ram.sv]
// Two palette tables of 256 x 18 bits with registered read ports
module pdp_palette_ram (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Table access
  pdp_lut_if.mem lut
);

  logic pix_sel;
  logic cpu_sel;

  // ==========================================================================
  // One memory per table; both see the same write data, own enable
  for (genvar t = 0; t < pdp_pkg::NUM_TABLES; t++) begin : gen_tbl
    logic [pdp_pkg::ENTRY_W-1:0] mem [0:pdp_pkg::LUT_DEPTH-1];
    logic [pdp_pkg::ENTRY_W-1:0] pix_q;
    logic [pdp_pkg::ENTRY_W-1:0] cpu_q;
    // Read first: a read in the same cycle as a write returns the old word
    always_ff @(posedge clock_i) begin
      if (lut.wr_en[t]) begin
        mem[lut.wr_addr] <= lut.wr_data;
      end
      pix_q <= mem[lut.pix_addr];
      cpu_q <= mem[lut.cpu_addr];
    end
  end

  // Table selects are registered on the same edge as the read data, so they stay aligned with it
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pix_sel <= 1'b0;
      cpu_sel <= 1'b0;
    end else begin
      pix_sel <= lut.pix_table;
      cpu_sel <= lut.cpu_table;
    end
  end

  assign lut.pix_data = pix_sel ? gen_tbl[1].pix_q : gen_tbl[0].pix_q;
  assign lut.cpu_data = cpu_sel ? gen_tbl[1].cpu_q : gen_tbl[0].cpu_q;

endmodule : pdp_palette_ram

// [hw/pdp_pixel_path.sv]
// Palette and DAC pixel path: palette ports, color modes, CRT/TV select
module pdp_pixel_path (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Palette I/O cycles from the bus
  input wire logic [15:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic io_master_abort_i,
  input wire logic pci_snoop_en_i,
  output logic [7:0] io_rdata_o,
  output logic io_rvalid_o,
  output logic io_claim_o,
  output logic io_retry_o,
  // Control register fields
  input wire logic [7:0] color_mode_control_i,
  input wire logic [7:0] tv_output_control_i,
  input wire logic [1:0] table_write_select_i,
  input wire logic [2:0] bus_abort_retry_control_i,
  input wire logic display_table_sel_i,
  // Pixel streams, cursor and TV encoder samples
  input wire logic pixel_valid_i,
  input wire logic [23:0] pixel_bus_bits_i,
  input wire logic comp_valid_i,
  input wire logic [23:0] comp_pixel_i,
  input wire logic cursor_en_i,
  input wire logic [23:0] cursor_rgb_i,
  input wire logic [7:0] tv_luma_i,
  input wire logic [7:0] tv_chroma_i,
  input wire logic sense_n_i,
  // DAC codes and output status
  output logic [7:0] analog_red_out_o,
  output logic [7:0] analog_green_out_o,
  output logic [7:0] analog_blue_out_o,
  output logic dac_valid_o,
  output logic crt_enable_o,
  output logic tv_enable_o,
  output logic [2:0] tv_format_o,
  output logic tv_pal_o,
  output logic tv_mono_o,
  output logic ctrl1_comp_src_o,
  output logic comp_lookup_valid_o,
  output logic [17:0] comp_lookup_rgb_o,
  output logic mode_rate_ok_o
);

  pdp_lut_if lut ();

  // ==========================================================================
  // Palette memory
  pdp_palette_ram u_ram (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .lut(lut.mem)
  );

  // ==========================================================================
  // Palette port state
  logic [7:0] mask, next_mask;
  logic [7:0] wr_index, next_wr_index;
  logic [7:0] rd_index, next_rd_index;
  pdp_pkg::pdp_cmp_t wr_cmp, next_wr_cmp;
  pdp_pkg::pdp_cmp_t rd_cmp, next_rd_cmp;
  logic [5:0] wr_red, next_wr_red;
  logic [5:0] wr_green, next_wr_green;
  logic rd_busy, next_rd_busy;
  logic dac_reading, next_dac_reading;
  logic [1:0] wr_en, next_wr_en;
  logic [7:0] wr_addr, next_wr_addr;
  logic [17:0] wr_data, next_wr_data;
  logic [7:0] next_io_rdata;
  logic next_io_rvalid, next_io_claim, next_io_retry;
  logic pal_hit;

  // Port decode, component sequencing, claim and retry
  always_comb begin
    next_mask = mask;
    next_wr_index = wr_index;
    next_rd_index = rd_index;
    next_wr_cmp = wr_cmp;
    next_rd_cmp = rd_cmp;
    next_wr_red = wr_red;
    next_wr_green = wr_green;
    next_rd_busy = 1'b0;
    next_dac_reading = dac_reading;
    next_wr_en = 2'b00;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_io_rdata = io_rdata_o;
    next_io_rvalid = 1'b0;
    next_io_claim = 1'b0;
    next_io_retry = 1'b0;
    pal_hit = (io_addr_i >= pdp_pkg::PORT_MASK) && (io_addr_i <= pdp_pkg::PORT_DATA);
    // A write in the same cycle as a read wins; the bus never issues both
    if (io_wr_i) begin
      next_io_claim = pal_hit && !pci_snoop_en_i;
      // Aborted writes leave the palette untouched when handling is enabled
      if (!(io_master_abort_i && bus_abort_retry_control_i[pdp_pkg::ABR_MABORT])) begin
        case (io_addr_i)
          pdp_pkg::PORT_MASK: begin
            next_mask = io_wdata_i;
          end
          pdp_pkg::PORT_RD_INDEX: begin
            next_rd_index = io_wdata_i;
            next_rd_cmp = pdp_pkg::CMP_RED;
            next_rd_busy = 1'b1;
            next_dac_reading = 1'b1;
          end
          pdp_pkg::PORT_WR_INDEX: begin
            next_wr_index = io_wdata_i;
            next_wr_cmp = pdp_pkg::CMP_RED;
            next_dac_reading = 1'b0;
          end
          pdp_pkg::PORT_DATA: begin
            if ((wr_en != 2'b00) && bus_abort_retry_control_i[pdp_pkg::ABR_WR_RETRY]) begin
              next_io_retry = 1'b1;
            end else begin
              case (wr_cmp)
                pdp_pkg::CMP_RED: begin
                  next_wr_red = io_wdata_i[5:0];
                  next_wr_cmp = pdp_pkg::CMP_GREEN;
                end
                pdp_pkg::CMP_GREEN: begin
                  next_wr_green = io_wdata_i[5:0];
                  next_wr_cmp = pdp_pkg::CMP_BLUE;
                end
                pdp_pkg::CMP_BLUE: begin
                  // Commit the whole entry at once, steered per table
                  case (table_write_select_i)
                    pdp_pkg::TWS_MIRROR: next_wr_en = 2'b11;
                    pdp_pkg::TWS_FIRST: next_wr_en = 2'b01;
                    pdp_pkg::TWS_SECOND: next_wr_en = 2'b10;
                    default: next_wr_en = 2'b00;
                  endcase
                  next_wr_addr = wr_index;
                  next_wr_data = {wr_red, wr_green, io_wdata_i[5:0]};
                  next_wr_index = wr_index + 8'h01;
                  next_wr_cmp = pdp_pkg::CMP_RED;
                end
                default: begin
                  next_wr_cmp = pdp_pkg::CMP_RED;
                end
              endcase
            end
          end
          default: begin
          end
        endcase
      end
    end else if (io_rd_i) begin
      next_io_claim = pal_hit || (io_addr_i == pdp_pkg::PORT_STATUS);
      next_io_rvalid = next_io_claim;
      case (io_addr_i)
        pdp_pkg::PORT_STATUS: begin
          next_io_rdata = 8'h00;
          next_io_rdata[pdp_pkg::SENSE_BIT] = sense_n_i;
        end
        pdp_pkg::PORT_MASK: begin
          next_io_rdata = mask;
        end
        pdp_pkg::PORT_RD_INDEX: begin
          next_io_rdata = dac_reading ? 8'h03 : 8'h00;
        end
        pdp_pkg::PORT_WR_INDEX: begin
          next_io_rdata = wr_index;
        end
        pdp_pkg::PORT_DATA: begin
          // Entry fetch takes one cycle after each index change
          if (rd_busy && bus_abort_retry_control_i[pdp_pkg::ABR_RD_RETRY]) begin
            next_io_retry = 1'b1;
            next_io_rvalid = 1'b0;
          end else begin
            case (rd_cmp)
              pdp_pkg::CMP_RED: begin
                next_io_rdata = {2'b00, lut.cpu_data[17:12]};
                next_rd_cmp = pdp_pkg::CMP_GREEN;
              end
              pdp_pkg::CMP_GREEN: begin
                next_io_rdata = {2'b00, lut.cpu_data[11:6]};
                next_rd_cmp = pdp_pkg::CMP_BLUE;
              end
              pdp_pkg::CMP_BLUE: begin
                next_io_rdata = {2'b00, lut.cpu_data[5:0]};
                next_rd_cmp = pdp_pkg::CMP_RED;
                next_rd_index = rd_index + 8'h01;
                next_rd_busy = 1'b1;
              end
              default: begin
                next_rd_cmp = pdp_pkg::CMP_RED;
              end
            endcase
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Palette port registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mask <= pdp_pkg::MASK_RESET;
      wr_index <= 8'h00;
      rd_index <= 8'h00;
      wr_cmp <= pdp_pkg::CMP_RED;
      rd_cmp <= pdp_pkg::CMP_RED;
      wr_red <= 6'h00;
      wr_green <= 6'h00;
      rd_busy <= 1'b1;
      dac_reading <= 1'b0;
      wr_en <= 2'b00;
      wr_addr <= 8'h00;
      wr_data <= 18'h00000;
      io_rdata_o <= 8'h00;
      io_rvalid_o <= 1'b0;
      io_claim_o <= 1'b0;
      io_retry_o <= 1'b0;
    end else begin
      mask <= next_mask;
      wr_index <= next_wr_index;
      rd_index <= next_rd_index;
      wr_cmp <= next_wr_cmp;
      rd_cmp <= next_rd_cmp;
      wr_red <= next_wr_red;
      wr_green <= next_wr_green;
      rd_busy <= next_rd_busy;
      dac_reading <= next_dac_reading;
      wr_en <= next_wr_en;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      io_rdata_o <= next_io_rdata;
      io_rvalid_o <= next_io_rvalid;
      io_claim_o <= next_io_claim;
      io_retry_o <= next_io_retry;
    end
  end

  // ==========================================================================
  // Pixel pipeline: latch, lookup or bypass, DAC register
  logic s1_valid, next_s1_valid;
  logic s1_phase, next_s1_phase;
  logic [23:0] s1_word, next_s1_word;
  logic [3:0] s1_mode, next_s1_mode;
  logic s1_comp, next_s1_comp;
  logic s1_cvalid, next_s1_cvalid;
  logic [23:0] s1_cpix, next_s1_cpix;
  logic s1_cur_en, next_s1_cur_en;
  logic [23:0] s1_cur, next_s1_cur;
  logic s1_lut;
  logic s2_valid, next_s2_valid;
  logic s2_use_lut, next_s2_use_lut;
  logic s2_to_comp, next_s2_to_comp;
  logic [23:0] s2_bypass, next_s2_bypass;
  logic s2_cur_en, next_s2_cur_en;
  logic [23:0] s2_cur, next_s2_cur;
  logic [7:0] next_red, next_green, next_blue;
  logic next_dac_valid, next_clv;
  logic [17:0] next_clrgb;
  logic comp_in, tv_in;
  logic next_rate_ok;

  // Mode, compositor and cursor controls are taken with each pixel so in-flight data keeps its mode
  assign tv_in = tv_output_control_i[pdp_pkg::TV_EN_BIT];
  assign comp_in = (color_mode_control_i[pdp_pkg::CM_COMP_LSB +: 2] == pdp_pkg::COMP_ON)
                   || tv_in;
  assign s1_lut = !((s1_mode == pdp_pkg::MODE_HI15) || (s1_mode == pdp_pkg::MODE_HI16)
                 || (s1_mode == pdp_pkg::MODE_PACKED24) || (s1_mode == pdp_pkg::MODE_TRUE24));
  // Low byte on the first phase, high byte on the second
  assign lut.pix_addr = (s1_phase ? s1_word[15:8] : s1_word[7:0]) & mask;
  assign lut.pix_table = s1_comp ? 1'b0 : display_table_sel_i;
  assign lut.cpu_addr = rd_index;
  assign lut.cpu_table = (table_write_select_i == pdp_pkg::TWS_SECOND);
  assign lut.wr_en = wr_en;
  assign lut.wr_addr = wr_addr;
  assign lut.wr_data = wr_data;

  // Stage one and stage two next values
  always_comb begin
    next_s1_valid = 1'b0;
    next_s1_phase = 1'b0;
    next_s1_word = s1_word;
    next_s1_mode = s1_mode;
    next_s1_comp = s1_comp;
    next_s1_cur_en = s1_cur_en;
    next_s1_cur = s1_cur;
    next_s1_cvalid = comp_valid_i;
    next_s1_cpix = comp_pixel_i;
    if (pixel_valid_i) begin
      next_s1_valid = 1'b1;
      next_s1_word = pixel_bus_bits_i;
      next_s1_mode = color_mode_control_i[pdp_pkg::CM_MODE_LSB +: 4];
      next_s1_comp = comp_in;
      next_s1_cur_en = cursor_en_i;
      next_s1_cur = cursor_rgb_i;
    end else if (s1_valid && !s1_phase && !s1_comp && (s1_mode == pdp_pkg::MODE_DOUBLED)) begin
      next_s1_valid = 1'b1;
      next_s1_phase = 1'b1;
    end
    next_s2_valid = s1_comp ? s1_cvalid : s1_valid;
    next_s2_use_lut = !s1_comp && s1_lut;
    next_s2_to_comp = s1_comp && s1_valid && s1_lut;
    next_s2_cur_en = s1_cur_en;
    next_s2_cur = s1_cur;
    // Bypass formats widened to 8 bits per DAC by replicating the top bits
    case (s1_mode)
      pdp_pkg::MODE_HI15: begin
        next_s2_bypass = {s1_word[14:10], s1_word[14:12], s1_word[9:5], s1_word[9:7],
                          s1_word[4:0], s1_word[4:2]};
      end
      pdp_pkg::MODE_HI16: begin
        next_s2_bypass = {s1_word[15:11], s1_word[15:13], s1_word[10:5], s1_word[10:9],
                          s1_word[4:0], s1_word[4:2]};
      end
      default: begin
        next_s2_bypass = s1_word[23:0];
      end
    endcase
    if (s1_comp) begin
      next_s2_bypass = s1_cpix;
    end
  end

  // Output stage: lookup expansion, cursor, TV routing
  always_comb begin
    next_dac_valid = s2_valid;
    next_clv = s2_to_comp;
    next_clrgb = lut.pix_data;
    if (s2_use_lut) begin
      next_red = {lut.pix_data[17:12], lut.pix_data[17:16]};
      next_green = {lut.pix_data[11:6], lut.pix_data[11:10]};
      next_blue = {lut.pix_data[5:0], lut.pix_data[5:4]};
    end else begin
      next_red = s2_bypass[23:16];
      next_green = s2_bypass[15:8];
      next_blue = s2_bypass[7:0];
    end
    // Cursor stays usable in every mode, packed 24-bit included
    if (s2_cur_en) begin
      next_red = s2_cur[23:16];
      next_green = s2_cur[15:8];
      next_blue = s2_cur[7:0];
    end
    if (!s2_valid) begin
      next_red = 8'h00;
      next_green = 8'h00;
      next_blue = 8'h00;
    end
    // TV drives only red and green; composite appears on both
    if (tv_in) begin
      next_dac_valid = 1'b1;
      next_green = tv_luma_i;
      next_red = (tv_output_control_i[pdp_pkg::TV_FMT_LSB +: 2] == pdp_pkg::TV_FMT_SVIDEO)
                 ? tv_chroma_i : tv_luma_i;
      next_blue = 8'h00;
    end
    // Rate limit check of the selected mode against this clock
    case (s1_mode)
      pdp_pkg::MODE_INDEXED, pdp_pkg::MODE_HI15, pdp_pkg::MODE_HI16: begin
        next_rate_ok = pdp_pkg::CLOCK_HZ <= pdp_pkg::MAX_HZ_80;
      end
      pdp_pkg::MODE_DOUBLED: begin
        next_rate_ok = (pdp_pkg::DOT_HZ_DOUBLED <= pdp_pkg::MAX_DOT_HZ_DOUBLED)
                       && (pdp_pkg::CLOCK_HZ <= pdp_pkg::MAX_PIX_HZ_DOUBLED);
      end
      pdp_pkg::MODE_PACKED24: begin
        next_rate_ok = (pdp_pkg::CLOCK_HZ <= pdp_pkg::MAX_DOT_HZ_PACKED24)
                       && (pdp_pkg::CLOCK_HZ <= pdp_pkg::MAX_PIX_HZ_PACKED24);
      end
      pdp_pkg::MODE_TRUE24: begin
        next_rate_ok = pdp_pkg::CLOCK_HZ <= pdp_pkg::MAX_HZ_TRUE24;
      end
      default: begin
        next_rate_ok = 1'b0;
      end
    endcase
  end

  // Pipeline and output registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s1_valid <= 1'b0;
      s1_phase <= 1'b0;
      s1_word <= 24'h000000;
      s1_mode <= pdp_pkg::MODE_INDEXED;
      s1_comp <= 1'b0;
      s1_cvalid <= 1'b0;
      s1_cpix <= 24'h000000;
      s1_cur_en <= 1'b0;
      s1_cur <= 24'h000000;
      s2_valid <= 1'b0;
      s2_use_lut <= 1'b0;
      s2_to_comp <= 1'b0;
      s2_bypass <= 24'h000000;
      s2_cur_en <= 1'b0;
      s2_cur <= 24'h000000;
      analog_red_out_o <= 8'h00;
      analog_green_out_o <= 8'h00;
      analog_blue_out_o <= 8'h00;
      dac_valid_o <= 1'b0;
      comp_lookup_valid_o <= 1'b0;
      comp_lookup_rgb_o <= 18'h00000;
      mode_rate_ok_o <= 1'b0;
      crt_enable_o <= 1'b1;
      tv_enable_o <= 1'b0;
      tv_format_o <= 3'h0;
      tv_pal_o <= 1'b0;
      tv_mono_o <= 1'b0;
      ctrl1_comp_src_o <= 1'b0;
    end else begin
      s1_valid <= next_s1_valid;
      s1_phase <= next_s1_phase;
      s1_word <= next_s1_word;
      s1_mode <= next_s1_mode;
      s1_comp <= next_s1_comp;
      s1_cvalid <= next_s1_cvalid;
      s1_cpix <= next_s1_cpix;
      s1_cur_en <= next_s1_cur_en;
      s1_cur <= next_s1_cur;
      s2_valid <= next_s2_valid;
      s2_use_lut <= next_s2_use_lut;
      s2_to_comp <= next_s2_to_comp;
      s2_bypass <= next_s2_bypass;
      s2_cur_en <= next_s2_cur_en;
      s2_cur <= next_s2_cur;
      analog_red_out_o <= next_red;
      analog_green_out_o <= next_green;
      analog_blue_out_o <= next_blue;
      dac_valid_o <= next_dac_valid;
      comp_lookup_valid_o <= next_clv;
      comp_lookup_rgb_o <= next_clrgb;
      mode_rate_ok_o <= next_rate_ok;
      crt_enable_o <= !tv_in;
      tv_enable_o <= tv_in;
      tv_format_o <= tv_output_control_i[pdp_pkg::TV_FMT_LSB +: 3];
      tv_pal_o <= tv_output_control_i[pdp_pkg::TV_PAL_BIT];
      tv_mono_o <= tv_output_control_i[pdp_pkg::TV_MONO_BIT];
      ctrl1_comp_src_o <= comp_in;
    end
  end

endmodule : pdp_pixel_path

// [verification/pdp_monitor_model.sv]
// Monitor load model driving the sense comparator
module pdp_monitor_model (
  // DAC codes
  input wire logic [7:0] r_i,
  input wire logic [7:0] g_i,
  input wire logic [7:0] b_i,
  // Sense, active low
  output logic sense_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Any bright channel trips sense; a code near black never does
  assign sense_n_o = !(r_i > 8'h40 || g_i > 8'h40 || b_i > 8'h40);
endmodule : pdp_monitor_model

// [verification/pdp_assertions.sv]
// Port checker for the pixel path
module pdp_assertions (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [15:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic io_master_abort_i,
  input wire logic pci_snoop_en_i,
  input wire logic sense_n_i,
  input wire logic pixel_valid_i,
  input wire logic [7:0] tv_output_control_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic io_rvalid_o,
  input wire logic io_claim_o,
  input wire logic io_retry_o,
  input wire logic dac_valid_o,
  input wire logic crt_enable_o,
  input wire logic tv_enable_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // A palette write that is neither aborted nor outside the port range
  sequence s_pal_wr;
    io_wr_i && !io_master_abort_i && io_addr_i >= 16'h03C6 && io_addr_i <= 16'h03C9;
  endsequence
  sequence s_rd(logic [15:0] a);
    io_rd_i && !io_wr_i && io_addr_i == a;
  endsequence
  a_one_target: assert property (crt_enable_o != tv_enable_o) else $error("two targets");
  a_tv_select: assert property (tv_output_control_i[0] |=> tv_enable_o) else $error("no tv");
  a_claim_all: assert property (s_pal_wr ##0 !pci_snoop_en_i |=> io_claim_o || io_retry_o)
    else $error("unclaimed");
  a_snoop_quiet: assert property (io_wr_i && pci_snoop_en_i |=> !io_claim_o)
    else $error("snoop claim");
  a_read_answer: assert property (s_rd(16'h03C6) |=> io_rvalid_o && io_claim_o)
    else $error("no answer");
  a_no_spur: assert property (io_rvalid_o |-> $past(io_rd_i) && !$past(io_wr_i))
    else $error("spurious");
  a_sense_bit: assert property (s_rd(16'h03C2) |=> io_rdata_o[4] == $past(sense_n_i))
    else $error("sense bit");
  a_dac_delay: assert property (pixel_valid_i |-> ##3 dac_valid_o) else $error("late");
endmodule : pdp_assertions
bind pdp_pixel_path pdp_assertions u_chk (.*);

// [verification/tb.sv]
// Self-checking bench for the pixel path
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i, rst_i, io_rd_i, io_wr_i, io_master_abort_i, pci_snoop_en_i, io_rvalid_o;
  logic io_claim_o, io_retry_o, display_table_sel_i, pixel_valid_i, comp_valid_i, cursor_en_i;
  logic sense_n_i, dac_valid_o, crt_enable_o, tv_enable_o, tv_pal_o, tv_mono_o;
  logic ctrl1_comp_src_o, comp_lookup_valid_o, mode_rate_ok_o;
  logic [15:0] io_addr_i;
  logic [7:0] io_wdata_i, io_rdata_o, color_mode_control_i, tv_output_control_i, tv_luma_i;
  logic [7:0] tv_chroma_i, analog_red_out_o, analog_green_out_o, analog_blue_out_o, q, mask;
  logic [1:0] table_write_select_i;
  logic [2:0] bus_abort_retry_control_i, tv_format_o;
  logic [23:0] pixel_bus_bits_i, comp_pixel_i, cursor_rgb_i, p;
  logic [17:0] comp_lookup_rgb_o, v;
  int mismatches, comparisons, lut[256];
  pdp_pixel_path dut (.*);
  pdp_monitor_model mon (.r_i(analog_red_out_o), .g_i(analog_green_out_o),
    .b_i(analog_blue_out_o), .sense_n_o(sense_n_i));
  // Free-running 25 MHz clock
  initial begin
    clock_i = 0;
    forever #20 clock_i = ~clock_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk
  task automatic end_sim();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  // One port access; two cycles keeps every data-port spacing rule
  task automatic io(input logic [15:0] a, input logic w, input logic [7:0] d);
    {io_addr_i, io_wr_i, io_rd_i, io_wdata_i} = {a, w, !w, d};
    @(posedge clock_i);
    #1 {io_wr_i, io_rd_i} = 2'b00;
    @(posedge clock_i);
    #1 q = io_rdata_o;
  endtask : io
  // DAC codes against one expected pixel
  task automatic dac(input logic [23:0] want);
    chk({dac_valid_o, analog_red_out_o, analog_green_out_o, analog_blue_out_o}, {1'b1, want});
  endtask : dac
  // One pixel, then a bounded wait for it at the DACs
  task automatic pix(input logic [23:0] want);
    {pixel_bus_bits_i, pixel_valid_i} = {p, 1'b1};
    @(posedge clock_i);
    #1 pixel_valid_i = 0;
    for (int n = 0; n < 6 && dac_valid_o !== 1'b1; n++) @(posedge clock_i) #1;
    dac(want);
  endtask : pix
  function automatic logic [7:0] wid(input logic [5:0] x);
    return {x, x[5:4]};
  endfunction : wid
  // Watchdog, well past the expected run length
  initial begin
    #800000;
    mismatches++;
    end_sim();
  end
  // ==========================================
  // Main sequence
  initial begin
    {io_rd_i, io_wr_i, io_master_abort_i, pci_snoop_en_i, pixel_valid_i, comp_valid_i} = 0;
    {cursor_en_i, io_addr_i, io_wdata_i, color_mode_control_i, tv_output_control_i} = 0;
    {table_write_select_i, bus_abort_retry_control_i, pixel_bus_bits_i} = {2'h0, 3'h7, 24'h0};
    void'($urandom(73870));
    {display_table_sel_i, comp_pixel_i, cursor_rgb_i, tv_luma_i, tv_chroma_i} = $urandom;
    rst_i = 1;
    repeat (5) @(posedge clock_i);
    #1 rst_i = 0;
    chk({crt_enable_o, tv_enable_o}, 2'b10);
    io(16'h03C6, 0, 0);
    chk(q, 8'hFF);
    io(16'h03C8, 1, 0);
    for (int i = 0; i < 256; i++) begin
      lut[i] = $urandom & 18'h3FFFF;
      for (int c = 2; c >= 0; c--) io(16'h03C9, 1, 8'(lut[i] >> (6 * c)) & 8'h3F);
    end
    for (int i = 0; i < 256; i += 51) begin
      io(16'h03C7, 1, 8'(i));
      for (int c = 2; c >= 0; c--) begin
        io(16'h03C9, 0, 0);
        chk(q, (lut[i] >> (6 * c)) & 8'h3F);
      end
    end
    $display("palette test done");
    pci_snoop_en_i = 1;
    mask = 8'($urandom);
    io(16'h03C6, 1, mask);
    io(16'h03C6, 0, 0);
    chk(q, mask);
    // Aborted write must leave the mask alone
    io_master_abort_i = 1;
    io(16'h03C6, 1, ~mask);
    io_master_abort_i = 0;
    io(16'h03C6, 0, 0);
    chk(q, mask);
    pci_snoop_en_i = 0;
    for (int k = 0; k < 52; k++) begin
      p = 24'($urandom);
      v = 18'(lut[p[7:0] & mask]);
      if (k == 20) color_mode_control_i = 8'hD0;
      if (k == 30) color_mode_control_i = 8'h30;
      if (k == 36) color_mode_control_i = 8'h50;
      if (k == 42) {color_mode_control_i, cursor_en_i} = {8'h70, 1'b1};
      // Doubled mode assumes software already set the sequencer clock bits
      if (k == 48) {color_mode_control_i, cursor_en_i} = {8'h10, 1'b0};
      if (k == 29 || k == 47) chk(mode_rate_ok_o, 1);
      if (k < 20 || k >= 48) pix({wid(v[17:12]), wid(v[11:6]), wid(v[5:0])});
      else if (k < 30) pix(p);
      else if (k < 36) pix({p[14:10], p[14:12], p[9:5], p[9:7], p[4:0], p[4:2]});
      else if (k < 42) pix({p[15:11], p[15:13], p[10:5], p[10:9], p[4:0], p[4:2]});
      else pix(cursor_rgb_i);
      if (k >= 48) begin
        v = 18'(lut[p[15:8] & mask]);
        @(posedge clock_i) #1 dac({wid(v[17:12]), wid(v[11:6]), wid(v[5:0])});
      end
    end
    // Compositor on: low byte looked up for it, its own word on the DACs
    {color_mode_control_i, comp_valid_i, comp_pixel_i} = {8'h0C, 1'b1, 24'($urandom)};
    p = 24'($urandom);
    v = 18'(lut[p[7:0] & mask]);
    pix(comp_pixel_i);
    chk({comp_lookup_valid_o, comp_lookup_rgb_o}, {1'b1, v});
    $display("pixel test done");
    {color_mode_control_i, comp_valid_i, tv_output_control_i} = {8'h00, 1'b0, 8'h21};
    repeat (2) @(posedge clock_i);
    #1 chk({crt_enable_o, tv_enable_o, tv_pal_o}, 3'b011);
    chk({tv_mono_o, tv_format_o, ctrl1_comp_src_o}, 5'h01);
    chk({analog_red_out_o, analog_green_out_o}, {tv_chroma_i, tv_luma_i});
    io(16'h03C2, 0, 0);
    chk(q[4], !(tv_luma_i > 8'h40 || tv_chroma_i > 8'h40));
    $display("tv test done");
    end_sim();
  end
endmodule : tb
